// File: include/uv_sensor_params.svh
`ifndef UV_SENSOR_PARAMS_SVH
`define UV_SENSOR_PARAMS_SVH

// ==========================================
// Register offsets and reset values.
`define ADDR_MEASURE_SETUP  8'h08
`define ADDR_PAUSE_TIME     8'h09
`define ADDR_EDGE_COUNT     8'h0a
`define ADDR_PTR_OPTIONS    8'h0b
`define MEASURE_SETUP_RST   8'h40
`define MEASURE_SETUP_MASK  8'hdb
`define PAUSE_TIME_RST      8'h19
`define EDGE_COUNT_RST      8'h01
`define PTR_OPTIONS_RST     8'h73

// ==========================================
// Field positions.
`define SCHEME_HI           7
`define SCHEME_LO           6
`define HOLD_BIT            4
`define DRIVE_BIT           3
`define CLKSEL_HI           1
`define CLKSEL_LO           0
`define SRP_BIT             0

// ==========================================
// Pointer defaults and bus framing.
`define PTR_MEAS_DEF        8'h02
`define PTR_CFG_DEF         8'h00
`define BYTE_BITS           4'h8
`define LAST_BIT            4'h7

// ==========================================
// Timing.
`define CLK_MHZ             50
`define WAKE_US             4
`define WAKE_CYC            (`WAKE_US * `CLK_MHZ)
`define PAUSE_STEP_US       8
`define PAUSE_STEP_CYC      (`PAUSE_STEP_US * `CLK_MHZ)
`define MIN_GAP_TICKS       16'h0003
`define CONV_BASE_KHZ       1024
`define NCO_BITS            24
`define NCO_BASE            ((64'd`CONV_BASE_KHZ << `NCO_BITS) / (64'd1000 * `CLK_MHZ))

`endif

// File: include/uv_cfg_pkg.sv
`include "uv_sensor_params.svh"

package uv_cfg_pkg;

	// ==========================================
	// Mode and state types.
	typedef enum logic [1:0] {
		FREE_RUNNING_SCHEME  = 2'h0,
		PER_COMMAND_SCHEME   = 2'h1,
		EXT_START_SCHEME     = 2'h2,
		EXT_START_END_SCHEME = 2'h3
	} measure_scheme_t;

	typedef struct packed {
		measure_scheme_t scheme;
		logic            hold;
		logic            open_drain;
		logic [1:0]      clk_sel;
	} measure_cfg_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2c_lines_t;

	typedef enum logic [4:0] {
		S_IDLE  = 5'h01,
		S_HOLD  = 5'h02,
		S_WAKE  = 5'h04,
		S_CONV  = 5'h08,
		S_PAUSE = 5'h10
	} seq_state_t;

	typedef enum logic [6:0] {
		B_IDLE  = 7'h01,
		B_ADDR  = 7'h02,
		B_AACK  = 7'h04,
		B_WRITE = 7'h08,
		B_WACK  = 7'h10,
		B_READ  = 7'h20,
		B_RACK  = 7'h40
	} bus_state_t;

endpackage

// File: logic/trigger_fall_sync.sv
module trigger_fall_sync
	import uv_cfg_pkg::*;
(
	// Clocks and reset.
	input  wire logic trig_clk,
	input  wire logic clk,
	input  wire logic rst,
	// Trigger pin, synchronous to trig_clk.
	input  wire logic trig_pin,
	// One-cycle pulse per falling edge, in the clk domain.
	output logic      fall_pulse
);

	logic       pin_prev_r;
	logic       toggle_r;
	logic [2:0] sync_r;

	// ==========================================
	// Link side: each falling edge flips a toggle, so no edge is lost when clk is slower.
	always_ff @(posedge trig_clk or posedge rst) begin
		if (rst) begin
			pin_prev_r <= 1'b1;
			toggle_r   <= 1'b0;
		end else begin
			pin_prev_r <= trig_pin;
			if (pin_prev_r && !trig_pin) begin
				toggle_r <= ~toggle_r;
			end
		end
	end

	// ==========================================
	// Core side: two-flop synchroniser, then a change detector on the settled copies.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_r <= 3'h0;
		end else begin
			sync_r <= {sync_r[1:0], toggle_r};
		end
	end

	assign fall_pulse = sync_r[2] ^ sync_r[1];

endmodule // trigger_fall_sync

// File: logic/uv_sensor_mode_config_regs.sv
// Contract
// - measure_scheme bits 7:6 select free-running, per-command, external start, external start and end.
// - low_power_hold bit 4 enters hold when set, leaves when cleared, resets zero.
// - After hold clears, operation resumes within 4 us wake-up time.
// - done_pin_drive_type bit 3 selects push-pull (0) or open-drain (1) ready driver.
// - On a shared open-drain ready line, pull low while own measurement runs.
// - internal_clock_select bits 1:0 pick 1.024, 2.048, 4.096 or 8.192 MHz.
// - Except per-command, pause between measurements equals pause_time times 8 us.
// - A zero pause still leaves three conversion clock periods between measurements; code counts three unaligned conv_tick_r pulses, so two to three periods.
// - External start and end scheme ends after programmed count of further falling edges.
// - Writing zero to the edge count stores one instead.
// - With stop_resets_pointer low, STOP keeps the pointer; only writes set it.
// - With stop_resets_pointer high, STOP reloads pointer: 2h measuring, 0h configuring.
// - Pointer increments by one after every data byte transferred.
// - Written pointer then repeated START makes the read begin there.
// - Reserved option bits 7:1 reset to 0111001.
// - In external start and end scheme, trigger pulses define the conversion length.
module uv_sensor_mode_config_regs
	import uv_cfg_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR    = 7'h2a,
	parameter logic [15:0] CONV_CYCLES = 16'h0400
)
(
	// Clocks and reset.
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   trig_clk,
	// Two-wire register bus pins.
	input  wire logic   scl_i,
	input  wire logic   sda_i,
	output logic        sda_o,
	output logic        sda_oe,
	// External trigger.
	input  wire logic   external_trigger_pin,
	// Device state from the surrounding logic.
	input  wire logic   measuring_state,
	input  wire logic   start_cmd,
	// Ready pin.
	output logic        ready_o,
	output logic        ready_oe,
	// Status and configuration towards the datapath.
	output logic        standby_o,
	output logic        conv_tick_o,
	output measure_cfg_t cfg_o
);

	localparam int WAKE_BOUND = `WAKE_CYC;

	logic [1:0]   scl_meta_r;
	logic [1:0]   sda_meta_r;
	i2c_lines_t   ln_r;
	i2c_lines_t   ln_prev_r;
	bus_state_t   bus_st_r;
	logic [3:0]   bit_cnt_r;
	logic [7:0]   shift_r;
	logic [7:0]   ptr_r;
	logic         first_r;
	logic         rw_r;
	logic         nack_r;
	logic         sda_oe_r;
	logic         sda_o_r;
	logic [7:0]   setup_r;
	logic [7:0]   pause_time_r;
	logic [7:0]   edge_count_r;
	logic [7:0]   options_r;
	logic [7:0]   rd_byte;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_c;
	logic         stop_c;
	logic         byte_done;
	logic         wr_en;
	measure_cfg_t cfg;
	seq_state_t   st_r;
	logic [16:0]  cyc_cnt_r;
	logic [15:0]  tick_cnt_r;
	logic [7:0]   edges_left_r;
	logic [23:0]  nco_acc_r;
	logic         conv_tick_r;
	logic [23:0]  nco_inc;
	logic         trig_fall;
	logic         start_req;
	logic         conv_done;
	logic         ready_o_r;
	logic         ready_oe_r;
	logic         standby_r;

	// ==========================================
	// Pin synchronisers and bus condition detection.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_meta_r <= 2'h3;
			sda_meta_r <= 2'h3;
			ln_r       <= 2'h3;
			ln_prev_r  <= 2'h3;
		end else begin
			scl_meta_r <= {scl_meta_r[0], scl_i};
			sda_meta_r <= {sda_meta_r[0], sda_i};
			ln_r       <= '{scl: scl_meta_r[1], sda: sda_meta_r[1]};
			ln_prev_r  <= ln_r;
		end
	end

	assign scl_rise  = ln_r.scl && !ln_prev_r.scl;
	assign scl_fall  = !ln_r.scl && ln_prev_r.scl;
	assign start_c   = ln_r.scl && ln_prev_r.scl && ln_prev_r.sda && !ln_r.sda;
	assign stop_c    = ln_r.scl && ln_prev_r.scl && !ln_prev_r.sda && ln_r.sda;
	assign byte_done = scl_fall && (bit_cnt_r == `BYTE_BITS);
	assign wr_en     = (bus_st_r == B_WRITE) && byte_done && !first_r;

	// ==========================================
	// Read data selection.
	always_comb begin
		rd_byte = 8'h00;
		case (ptr_r)
			`ADDR_MEASURE_SETUP: rd_byte = setup_r;
			`ADDR_PAUSE_TIME:    rd_byte = pause_time_r;
			`ADDR_EDGE_COUNT:    rd_byte = edge_count_r;
			`ADDR_PTR_OPTIONS:   rd_byte = options_r;
			default:             rd_byte = 8'h00;
		endcase
	end

	// ==========================================
	// Bus slave: byte framing, acknowledge and register pointer.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_st_r  <= B_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r   <= 8'h00;
			ptr_r     <= `PTR_CFG_DEF;
			first_r   <= 1'b0;
			rw_r      <= 1'b0;
			nack_r    <= 1'b0;
			sda_oe_r  <= 1'b0;
			sda_o_r   <= 1'b0;
		end else if (start_c) begin
			bus_st_r  <= B_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_r  <= 1'b0;
		end else if (stop_c) begin
			bus_st_r <= B_IDLE;
			sda_oe_r <= 1'b0;
			if (options_r[`SRP_BIT]) begin
				ptr_r <= measuring_state ? `PTR_MEAS_DEF : `PTR_CFG_DEF;
			end
		end else begin
			unique case (bus_st_r)
				B_IDLE: begin
					sda_oe_r <= 1'b0;
				end
				B_ADDR: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], ln_r.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_done) begin
						if (shift_r[7:1] == DEV_ADDR) begin
							bus_st_r <= B_AACK;
							sda_oe_r <= 1'b1;
							rw_r     <= shift_r[0];
						end else begin
							bus_st_r <= B_IDLE;
						end
					end
				end
				B_AACK: begin
					if (scl_fall) begin
						bit_cnt_r <= 4'h0;
						first_r   <= 1'b1;
						if (rw_r) begin
							bus_st_r <= B_READ;
							shift_r  <= rd_byte;
							sda_oe_r <= ~rd_byte[7];
						end else begin
							bus_st_r <= B_WRITE;
							sda_oe_r <= 1'b0;
						end
					end
				end
				B_WRITE: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], ln_r.sda};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (byte_done) begin
						bus_st_r <= B_WACK;
						sda_oe_r <= 1'b1;
						first_r  <= 1'b0;
						ptr_r    <= first_r ? shift_r : ptr_r + 8'h01;
					end
				end
				B_WACK: begin
					if (scl_fall) begin
						bus_st_r  <= B_WRITE;
						bit_cnt_r <= 4'h0;
						sda_oe_r  <= 1'b0;
					end
				end
				B_READ: begin
					if (scl_fall) begin
						if (bit_cnt_r == `LAST_BIT) begin
							bus_st_r  <= B_RACK;
							sda_oe_r  <= 1'b0;
							bit_cnt_r <= 4'h0;
							ptr_r     <= ptr_r + 8'h01;
						end else begin
							shift_r   <= {shift_r[6:0], 1'b0};
							sda_oe_r  <= ~shift_r[6];
							bit_cnt_r <= bit_cnt_r + 4'h1;
						end
					end
				end
				B_RACK: begin
					if (scl_rise) begin
						nack_r <= ln_r.sda;
					end else if (scl_fall) begin
						if (nack_r) begin
							bus_st_r <= B_IDLE;
						end else begin
							bus_st_r <= B_READ;
							shift_r  <= rd_byte;
							sda_oe_r <= ~rd_byte[7];
						end
					end
				end
			endcase
		end
	end

	assign sda_o  = sda_o_r;
	assign sda_oe = sda_oe_r;

	// ==========================================
	// Configuration registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_r      <= `MEASURE_SETUP_RST;
			pause_time_r <= `PAUSE_TIME_RST;
			edge_count_r <= `EDGE_COUNT_RST;
			options_r    <= `PTR_OPTIONS_RST;
		end else if (wr_en) begin
			case (ptr_r)
				`ADDR_MEASURE_SETUP: setup_r <= shift_r & `MEASURE_SETUP_MASK;
				`ADDR_PAUSE_TIME:    pause_time_r <= shift_r;
				`ADDR_EDGE_COUNT:    edge_count_r <= (shift_r == 8'h00) ? `EDGE_COUNT_RST : shift_r;
				`ADDR_PTR_OPTIONS:   options_r <= shift_r;
				default:             ;
			endcase
		end
	end

	assign cfg = measure_cfg_t'({setup_r[`SCHEME_HI:`SCHEME_LO], setup_r[`HOLD_BIT], setup_r[`DRIVE_BIT],
		setup_r[`CLKSEL_HI:`CLKSEL_LO]});
	assign cfg_o = cfg;

	// ==========================================
	// Conversion clock: phase accumulator stepping at the selected rate.
	assign nco_inc = 24'(`NCO_BASE) << cfg.clk_sel;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nco_acc_r   <= 24'h000000;
			conv_tick_r <= 1'b0;
		end else begin
			{conv_tick_r, nco_acc_r} <= {1'b0, nco_acc_r} + {1'b0, nco_inc};
		end
	end

	assign conv_tick_o = conv_tick_r;

	trigger_fall_sync u_trig (
		.trig_clk   (trig_clk),
		.clk        (clk),
		.rst        (rst),
		.trig_pin   (external_trigger_pin),
		.fall_pulse (trig_fall)
	);

	// ==========================================
	// Measurement sequencer.
	always_comb begin
		start_req = 1'b0;
		unique case (cfg.scheme)
			FREE_RUNNING_SCHEME:  start_req = 1'b1;
			PER_COMMAND_SCHEME:   start_req = start_cmd;
			EXT_START_SCHEME:     start_req = trig_fall;
			EXT_START_END_SCHEME: start_req = trig_fall;
		endcase
	end

	assign conv_done = (cfg.scheme == EXT_START_END_SCHEME) ?
		(trig_fall && edges_left_r == 8'h01) : (tick_cnt_r == 16'h0000);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r         <= S_IDLE;
			cyc_cnt_r    <= 17'h00000;
			tick_cnt_r   <= 16'h0000;
			edges_left_r <= `EDGE_COUNT_RST;
		end else if (cfg.hold) begin
			st_r <= S_HOLD;
		end else begin
			unique case (st_r)
				S_HOLD: begin
					st_r      <= S_WAKE;
					cyc_cnt_r <= 17'(`WAKE_CYC - 1);
				end
				S_WAKE: begin
					if (cyc_cnt_r == 17'h00000) begin
						st_r <= S_IDLE;
					end else begin
						cyc_cnt_r <= cyc_cnt_r - 17'h00001;
					end
				end
				S_IDLE: begin
					if (measuring_state && start_req) begin
						st_r         <= S_CONV;
						tick_cnt_r   <= CONV_CYCLES;
						edges_left_r <= edge_count_r;
					end
				end
				S_CONV: begin
					if (!measuring_state) begin
						st_r <= S_IDLE;
					end else if (conv_done) begin
						st_r       <= (cfg.scheme == PER_COMMAND_SCHEME) ? S_IDLE : S_PAUSE;
						cyc_cnt_r  <= 17'(32'(pause_time_r) * `PAUSE_STEP_CYC);
						tick_cnt_r <= `MIN_GAP_TICKS;
					end else begin
						if (conv_tick_r && tick_cnt_r != 16'h0000) begin
							tick_cnt_r <= tick_cnt_r - 16'h0001;
						end
						if (trig_fall) begin
							edges_left_r <= edges_left_r - 8'h01;
						end
					end
				end
				S_PAUSE: begin
					if (!measuring_state || (cyc_cnt_r == 17'h00000 && tick_cnt_r == 16'h0000)) begin
						st_r <= S_IDLE;
					end else begin
						if (cyc_cnt_r != 17'h00000) begin
							cyc_cnt_r <= cyc_cnt_r - 17'h00001;
						end
						if (conv_tick_r && tick_cnt_r != 16'h0000) begin
							tick_cnt_r <= tick_cnt_r - 16'h0001;
						end
					end
				end
			endcase
		end
	end

	// ==========================================
	// Ready pin driver and standby flag.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_o_r  <= 1'b1;
			ready_oe_r <= 1'b1;
			standby_r  <= 1'b0;
		end else begin
			ready_o_r  <= cfg.open_drain ? 1'b0 : (st_r != S_CONV);
			ready_oe_r <= cfg.open_drain ? (st_r == S_CONV) : 1'b1;
			standby_r  <= (st_r == S_HOLD);
		end
	end

	assign ready_o   = ready_o_r;
	assign ready_oe  = ready_oe_r;
	assign standby_o = standby_r;

	// ==========================================
	// Assertions.
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	cmd_waits_a: assert property (st_r == S_IDLE && cfg.scheme == PER_COMMAND_SCHEME && !start_cmd && !cfg.hold
		|=> st_r == S_IDLE) else $error("per-command scheme started without a command");
	hold_enter_a: assert property (cfg.hold |=> st_r == S_HOLD ##1 standby_o)
		else $error("hold bit did not enter hold");
	wake_bound_a: assert property ($rose(st_r == S_WAKE) |-> ##[1:WAKE_BOUND] st_r != S_WAKE)
		else $error("wake-up took too long");
	drain_low_a: assert property (cfg.open_drain && st_r == S_CONV |=> ready_oe && !ready_o)
		else $error("open-drain ready not pulled low while busy");
	push_pull_a: assert property (!cfg.open_drain && st_r != S_CONV |=> ready_oe && ready_o)
		else $error("push-pull ready wrong when idle");
	cmd_no_pause_a: assert property (st_r == S_CONV && conv_done && measuring_state && !cfg.hold
		&& cfg.scheme == PER_COMMAND_SCHEME |=> st_r == S_IDLE) else $error("pause after per-command");
	min_gap_a: assert property (st_r == S_PAUSE && tick_cnt_r != 16'h0000 && measuring_state && !cfg.hold
		|=> st_r == S_PAUSE) else $error("pause shorter than three conversion clocks");
	edge_end_a: assert property (st_r == S_CONV && cfg.scheme == EXT_START_END_SCHEME && trig_fall
		&& edges_left_r == 8'h01 && measuring_state && !cfg.hold |=> st_r == S_PAUSE)
		else $error("edge-terminated conversion did not end");
	edge_nonzero_a: assert property (edge_count_r != 8'h00) else $error("edge count holds zero");
	stop_keep_a: assert property (stop_c && !options_r[`SRP_BIT] |=> $stable(ptr_r))
		else $error("stop moved pointer");
	stop_reload_a: assert property (stop_c && options_r[`SRP_BIT] |=> ptr_r == $past(measuring_state ?
		`PTR_MEAS_DEF : `PTR_CFG_DEF)) else $error("stop did not reload pointer");
	ptr_step_a: assert property (bus_st_r == B_READ && scl_fall && bit_cnt_r == `LAST_BIT && !start_c
		&& !stop_c |=> ptr_r == $past(ptr_r) + 8'h01) else $error("pointer did not step");
	restart_keep_a: assert property (start_c |=> $stable(ptr_r))
		else $error("repeated start moved pointer");
	spare_zero_a: assert property (setup_r[5] == 1'b0 && setup_r[2] == 1'b0)
		else $error("unused setup bits set");

	cov_free_running_scheme_c: cover property (cfg.scheme == FREE_RUNNING_SCHEME && st_r == S_PAUSE ##[1:300] st_r == S_CONV);
	cov_ext_start_end_scheme_c: cover property (cfg.scheme == EXT_START_END_SCHEME && st_r == S_CONV ##1 st_r == S_PAUSE);
	cov_wake_c: cover property (st_r == S_WAKE ##1 st_r == S_IDLE);
	cov_read_c: cover property (bus_st_r == B_RACK ##1 bus_st_r == B_READ);

endmodule // uv_sensor_mode_config_regs

// File: verification/uv_bus_host.sv
module uv_bus_host
	import uv_cfg_pkg::*;
#(
	parameter logic [6:0] DEV = 7'h2a
)
(
	// Bus wires.
	input  wire logic clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_pull,
	// Trigger link.
	output logic      trig_clk,
	output logic      trig,
	// Device acknowledged the last byte.
	output logic      acked
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		trig_clk = 1'b0;
		trig = 1'b1;
		acked = 1'b0;
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Data moves only while the bus clock is low, so no bit looks like a start or stop.
	task automatic put(input logic b, output logic s);
		sda_pull <= ~b;
		wt(6);
		scl <= 1'b1;
		wt(6);
		s = sda_w;
		scl <= 1'b0;
		wt(1);
	endtask

	// With the bus clock already low this is a repeated start.
	task automatic start_c;
		sda_pull <= 1'b0;
		wt(6);
		scl <= 1'b1;
		wt(6);
		sda_pull <= 1'b1;
		wt(6);
		scl <= 1'b0;
		wt(1);
	endtask

	task automatic stop_c;
		sda_pull <= 1'b1;
		wt(6);
		scl <= 1'b1;
		wt(6);
		sda_pull <= 1'b0;
		wt(6);
	endtask

	task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--)
			put(d[i], q[i]);
		put(~mack, a);
		acked = ~a;
	endtask

	task automatic begin_xfer(input logic rd);
		logic [7:0] q;
		start_c;
		xbyte({DEV, rd}, 1'b0, q);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] q;
		begin_xfer(1'b0);
		xbyte(p, 1'b0, q);
		xbyte(d, 1'b0, q);
		stop_c;
	endtask

	// The link clock runs only while the source signals.
	task automatic tcyc(input logic v);
		#24 trig_clk = 1'b1;
		trig <= v;
		#24 trig_clk = 1'b0;
	endtask

	task automatic edges(input int n);
		repeat (n) begin
			tcyc(1'b0);
			tcyc(1'b0);
			tcyc(1'b1);
			tcyc(1'b1);
		end
	endtask
endmodule // uv_bus_host

// File: verification/uv_sensor_mode_config_regs_tb_top.sv
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module uv_sensor_mode_config_regs_tb_top
	import uv_cfg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// Signals.
	typedef struct packed {
		logic [7:0] p;
		logic [7:0] w;
		logic [7:0] r;
	} row_t;
	localparam row_t ROWS [6] = '{'{8'h08, 8'hff, 8'hdb}, '{8'h09, 8'hff, 8'hff}, '{8'h09, 8'h01, 8'h01},
		'{8'h0a, 8'h00, 8'h01}, '{8'h0a, 8'h02, 8'h02}, '{8'h0c, 8'h5a, 8'h00}};
	localparam logic [7:0] RST_VALS [4] = '{8'h40, 8'h19, 8'h01, 8'h73};

	logic         clk, rst, meas, start, scl, sda_pull, trig_clk, trig, acked;
	logic         sda_o, sda_oe, ready_o, ready_oe, standby, tick;
	measure_cfg_t cfg;
	logic [7:0]   got [16];
	int           miscompares, n_tests, c;
	wire logic    sda_w = ~((sda_oe & ~sda_o) | sda_pull);
	wire logic    rdy   = ~(ready_oe & ~ready_o);

	uv_sensor_mode_config_regs #(.CONV_CYCLES(16'h0008)) dut (
		.clk(clk), .rst(rst), .trig_clk(trig_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .external_trigger_pin(trig), .measuring_state(meas), .start_cmd(start),
		.ready_o(ready_o), .ready_oe(ready_oe), .standby_o(standby), .conv_tick_o(tick), .cfg_o(cfg));

	uv_bus_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull), .trig_clk(trig_clk),
		.trig(trig), .acked(acked));

	always #10 clk = ~clk;

	// ==========================================
	// Tasks.
	task automatic tally_and_finish;
		if (miscompares == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic rd(input int n);
		host.begin_xfer(1'b1);
		for (int i = 0; i < n; i++)
			host.xbyte(8'hff, i < n - 1, got[i]);
		host.stop_c;
	endtask

	task automatic rdp(input logic [7:0] p, input int n);
		logic [7:0] q;
		host.begin_xfer(1'b0);
		host.xbyte(p, 1'b0, q);
		rd(n);
	endtask

	// The ready line is seen as the wire with its pull-up.
	task automatic waitr(input logic v);
		c = 0;
		while (rdy !== v && c < 3000) begin
			@(posedge clk);
			c++;
		end
	endtask

	task automatic do_rst;
		rst <= 1'b1;
		fork
			repeat (5) @(posedge clk);
			repeat (3) host.tcyc(1'b1);
		join
		@(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		`CHK(cfg, 6'h10)
		for (int i = 0; i < 4; i++) begin
			rdp(8'h08 + i[7:0], 1);
			`CHK(got[0], RST_VALS[i])
		end
	endtask

	initial begin
		#1900000;
		miscompares++;
		tally_and_finish;
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		meas = 1'b0;
		start = 1'b0;
		miscompares = 0;
		n_tests = 0;
		do_rst;
		foreach (ROWS[i]) begin
			host.wr(ROWS[i].p, ROWS[i].w);
			rdp(ROWS[i].p, 1);
			`CHK(got[0], ROWS[i].r)
		end
		for (int i = 0; i < 4; i++) begin
			host.wr(8'h08, {i[1:0], 4'h0, i[1:0]});
			`CHK(cfg, {i[1:0], 2'b00, i[1:0]})
			c = 0;
			repeat (1000) @(posedge clk) c += int'(tick);
			`CHK((c >= (20 << i)) && (c <= (21 << i) + 1), 1'b1)
		end
		meas <= 1'b1;
		host.wr(8'h08, 8'h50);
		`CHK(standby, 1'b1)
		host.wr(8'h08, 8'h40);
		`CHK(standby, 1'b0)
		repeat (190) @(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		waitr(1'b0);
		`CHK(c < 8, 1'b1)
		waitr(1'b1);
		host.wr(8'h08, 8'h00);
		waitr(1'b0);
		waitr(1'b1);
		waitr(1'b0);
		`CHK(c >= 398 && c <= 410, 1'b1)
		host.wr(8'h09, 8'h00);
		waitr(1'b0);
		waitr(1'b1);
		waitr(1'b0);
		`CHK(c >= 96 && c <= 160, 1'b1)
		meas <= 1'b0;
		host.wr(8'h08, 8'hc8);
		meas <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK(ready_oe, 1'b0)
		host.edges(1);
		repeat (6) @(posedge clk);
		`CHK(rdy, 1'b0)
		host.edges(1);
		repeat (6) @(posedge clk);
		`CHK(rdy, 1'b0)
		host.edges(1);
		repeat (6) @(posedge clk);
		`CHK(rdy, 1'b1)
		rd(1);
		rd(7);
		`CHK(got[6], 8'hc8)
		meas <= 1'b0;
		rd(1);
		rd(9);
		`CHK(got[8], 8'hc8)
		host.wr(8'h0b, 8'h00);
		host.begin_xfer(1'b0);
		host.xbyte(8'h08, 1'b0, got[0]);
		host.stop_c;
		rd(1);
		`CHK(got[0], 8'hc8)
		rd(2);
		`CHK(got[1], 8'h02)
		host.start_c;
		host.xbyte({7'h15, 1'b0}, 1'b0, got[0]);
		`CHK(acked, 1'b0)
		host.stop_c;
		do_rst;
		tally_and_finish;
	end
endmodule // uv_sensor_mode_config_regs_tb_top
